//--- include/iop_pkg.sv
// Constants, register map and carrier types for the pin and PWM control block
`default_nettype none
package iop_pkg;
  // Setup map byte addresses
  localparam logic [7:0] ADDR_DRIVE_SHARED = 8'h46;
  localparam logic [7:0] ADDR_DRIVE_DED = 8'h47;
  localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h49;
  localparam logic [7:0] ADDR_SHARED_PWM_EN = 8'h4a;
  localparam logic [7:0] ADDR_DED_PWM_EN = 8'h4b;
  localparam logic [7:0] ADDR_PWM_DUTY = 8'h4c;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h4d;
  // Values after reset
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
  localparam logic [7:0] RST_PWM_EN = 8'h00;
  localparam logic [7:0] RST_PWM_DUTY = 8'h00;
  localparam logic [7:0] RST_WAKE_EN = 8'h00;
  // Dedicated pins occupy bits 4 down to 2
  localparam int DED_LSB = 2;
  localparam int DED_MSB = 4;
  localparam int DED_PINS = 3;
  localparam int SHARED_LINES = 8;
  localparam logic [7:0] DED_MASK = 8'h1c;
  // Duty bands that give a constant level
  localparam logic [7:0] DUTY_LOW_MAX = 8'h0a;
  localparam logic [7:0] DUTY_HIGH_MIN = 8'hfa;
  // Timing
  localparam longint CLK_HZ = 50000000;
  localparam longint SAMPLE_MS = 16;
  localparam int SAMPLE_CYCLES = int'(SAMPLE_MS * CLK_HZ / 1000);
  localparam int PWM_TICK_CYCLES = 16;
  // Bus address of this slave, arbitrary value
  localparam logic [6:0] SLAVE_ADDR = 7'h2a;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } iop_wr_t;
endpackage
`default_nettype wire

//--- core/iop_pwm_gen.sv
// Shared duty-level PWM waveform generator
`default_nettype none
module iop_pwm_gen (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic measActive,
  input wire logic [7:0] dutyLevel,
  output logic pwmLevel
);
  import iop_pkg::*;

  logic [7:0] tickCnt_ff;
  logic [7:0] phase_ff;
  logic pwmLevel_ff;
  wire logic tick = (tickCnt_ff == 8'(PWM_TICK_CYCLES - 1));
  wire logic forceLow = (dutyLevel <= DUTY_LOW_MAX);
  wire logic forceHigh = (dutyLevel >= DUTY_HIGH_MIN);
  wire logic nxt_level = forceHigh | (~forceLow & (phase_ff < dutyLevel));

  // Counter and output both freeze during measurements, so duty accuracy drops with long bursts
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_ff <= 8'h00;
      phase_ff <= 8'h00;
      pwmLevel_ff <= 1'b0;
    end else if (!measActive) begin
      tickCnt_ff <= tick ? 8'h00 : tickCnt_ff + 8'h01;
      if (tick) begin
        phase_ff <= phase_ff + 8'h01;
      end
      pwmLevel_ff <= nxt_level;
    end
  end

  assign pwmLevel = pwmLevel_ff;
endmodule
`default_nettype wire

//--- core/iop_bus_slave.sv
// Two-wire byte-addressed slave port reaching the setup map
`default_nettype none
module iop_bus_slave (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdData,
  output iop_pkg::iop_wr_t regWr
);
  import iop_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_PTR, ST_WR, ST_RD, ST_RACK} iop_bus_st_t;
  typedef enum logic [1:0] {AK_READ, AK_WRITE, AK_PTR, AK_DATA} iop_ack_t;

  logic [1:0] sclSync_ff, sdaSync_ff;
  logic sclDly_ff, sdaDly_ff;
  iop_bus_st_t state_ff;
  iop_ack_t ackKind_ff;
  logic [7:0] shift_ff, ptr_ff;
  logic [2:0] bitCnt_ff;
  logic gotByte_ff, masterAck_ff, sdaOe_ff;
  iop_wr_t regWr_ff;

  // Bus pins are asynchronous to core_clk
  wire logic sclS = sclSync_ff[1];
  wire logic sdaS = sdaSync_ff[1];
  wire logic startCond = sclS & sclDly_ff & sdaDly_ff & ~sdaS;
  wire logic stopCond = sclS & sclDly_ff & ~sdaDly_ff & sdaS;
  wire logic sclRise = sclS & ~sclDly_ff;
  wire logic sclFall = ~sclS & sclDly_ff;
  wire logic [7:0] inByte = {shift_ff[6:0], sdaS};
  wire logic lastBit = (bitCnt_ff == 3'h7);
  wire logic takeIn = (state_ff == ST_ADDR) | (state_ff == ST_PTR) | (state_ff == ST_WR);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclSync_ff <= 2'h3;
      sdaSync_ff <= 2'h3;
      sclDly_ff <= 1'b1;
      sdaDly_ff <= 1'b1;
    end else begin
      sclSync_ff <= {sclSync_ff[0], sclIn};
      sdaSync_ff <= {sdaSync_ff[0], sdaIn};
      sclDly_ff <= sclS;
      sdaDly_ff <= sdaS;
    end
  end

  // Single and block accesses: the pointer advances after every data byte
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      ackKind_ff <= AK_WRITE;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      bitCnt_ff <= 3'h0;
      gotByte_ff <= 1'b0;
      masterAck_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
      regWr_ff <= '0;
    end else begin
      regWr_ff.valid <= 1'b0;
      if (startCond) begin
        state_ff <= ST_ADDR;
        bitCnt_ff <= 3'h0;
        gotByte_ff <= 1'b0;
        sdaOe_ff <= 1'b0;
      end else if (stopCond) begin
        state_ff <= ST_IDLE;
        sdaOe_ff <= 1'b0;
      end else if (sclRise && takeIn && !gotByte_ff) begin
        shift_ff <= inByte;
        bitCnt_ff <= bitCnt_ff + 3'h1;
        if (lastBit) begin
          gotByte_ff <= 1'b1;
          if (state_ff == ST_PTR) begin
            ptr_ff <= inByte;
          end else if (state_ff == ST_WR) begin
            regWr_ff <= '{valid: 1'b1, addr: ptr_ff, data: inByte};
            ptr_ff <= ptr_ff + 8'h01;
          end
        end
      end else if (sclRise && state_ff == ST_RACK) begin
        masterAck_ff <= ~sdaS;
      end else if (sclFall) begin
        unique case (state_ff)
          ST_ADDR, ST_PTR, ST_WR: begin
            if (gotByte_ff) begin
              gotByte_ff <= 1'b0;
              if (state_ff == ST_ADDR && shift_ff[7:1] != SLAVE_ADDR) begin
                state_ff <= ST_IDLE;
              end else begin
                state_ff <= ST_ACK;
                sdaOe_ff <= 1'b1;
                if (state_ff == ST_ADDR) begin
                  ackKind_ff <= shift_ff[0] ? AK_READ : AK_WRITE;
                end else begin
                  ackKind_ff <= (state_ff == ST_PTR) ? AK_PTR : AK_DATA;
                end
              end
            end
          end
          ST_ACK: begin
            bitCnt_ff <= 3'h0;
            if (ackKind_ff == AK_READ) begin
              state_ff <= ST_RD;
              shift_ff <= rdData;
              sdaOe_ff <= ~rdData[7];
              ptr_ff <= ptr_ff + 8'h01;
            end else begin
              state_ff <= (ackKind_ff == AK_WRITE) ? ST_PTR : ST_WR;
              sdaOe_ff <= 1'b0;
            end
          end
          ST_RD: begin
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (lastBit) begin
              state_ff <= ST_RACK;
              sdaOe_ff <= 1'b0;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              sdaOe_ff <= ~shift_ff[6];
            end
          end
          ST_RACK: begin
            // A missing acknowledge ends the read; the slave returns to ST_IDLE and waits for the next start
            if (masterAck_ff) begin
              state_ff <= ST_RD;
              bitCnt_ff <= 3'h0;
              shift_ff <= rdData;
              sdaOe_ff <= ~rdData[7];
              ptr_ff <= ptr_ff + 8'h01;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            sdaOe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_ff;
  assign rdAddr = ptr_ff;
  assign regWr = regWr_ff;
endmodule
`default_nettype wire

//--- core/iop_pin_ctrl.sv
// General-purpose pin control: setup bytes, input sampling, sleep wake and output drive
`default_nettype none
module iop_pin_ctrl #(
  parameter int SAMPLE_CYCLES = iop_pkg::SAMPLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic measActive,
  input wire logic sleepMode,
  input wire logic [7:0] scanBurst,
  output logic [7:0] scanLineOut,
  input wire logic [2:0] dedPinIn,
  output logic [2:0] dedPinOut,
  output logic [2:0] dedPinOe,
  output logic [2:0] dedPinState,
  output logic wakeChange
);
  import iop_pkg::*;

  logic [7:0] driveShared_ff, driveDed_ff, pinDir_ff, sharedPwmEn_ff;
  logic [7:0] dedPwmEn_ff, pwmDuty_ff, wakeEn_ff;
  logic [2:0] pinSync1_ff, pinSync2_ff, pinSample_ff;
  logic [31:0] sampleCnt_ff;
  logic [7:0] scanLine_ff;
  logic [2:0] dedOut_ff, dedOe_ff;
  logic wakeChange_ff;
  logic pwmLevel;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  iop_wr_t regWr;

  iop_bus_slave u_bus (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .regWr(regWr)
  );

  iop_pwm_gen u_pwm (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .measActive(measActive),
    .dutyLevel(pwmDuty_ff),
    .pwmLevel(pwmLevel)
  );

  // Write strobes
  wire logic wrDriveShared = regWr.valid & (regWr.addr == ADDR_DRIVE_SHARED);
  wire logic wrDriveDed = regWr.valid & (regWr.addr == ADDR_DRIVE_DED);
  wire logic wrPinDir = regWr.valid & (regWr.addr == ADDR_PIN_DIRECTION);
  wire logic wrSharedPwm = regWr.valid & (regWr.addr == ADDR_SHARED_PWM_EN);
  wire logic wrDedPwm = regWr.valid & (regWr.addr == ADDR_DED_PWM_EN);
  wire logic wrDuty = regWr.valid & (regWr.addr == ADDR_PWM_DUTY);
  wire logic wrWake = regWr.valid & (regWr.addr == ADDR_WAKE_EN);

  // Read mux; addresses outside this block read zero
  assign rdData = (rdAddr == ADDR_DRIVE_SHARED) ? driveShared_ff :
                  (rdAddr == ADDR_DRIVE_DED) ? driveDed_ff :
                  (rdAddr == ADDR_PIN_DIRECTION) ? pinDir_ff :
                  (rdAddr == ADDR_SHARED_PWM_EN) ? sharedPwmEn_ff :
                  (rdAddr == ADDR_DED_PWM_EN) ? dedPwmEn_ff :
                  (rdAddr == ADDR_PWM_DUTY) ? pwmDuty_ff :
                  (rdAddr == ADDR_WAKE_EN) ? wakeEn_ff : 8'h00;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      driveShared_ff <= RST_DRIVE;
      driveDed_ff <= RST_DRIVE;
      pinDir_ff <= RST_PIN_DIRECTION;
      sharedPwmEn_ff <= RST_PWM_EN;
      dedPwmEn_ff <= RST_PWM_EN;
      pwmDuty_ff <= RST_PWM_DUTY;
      wakeEn_ff <= RST_WAKE_EN;
    end else begin
      if (wrDriveShared) begin
        driveShared_ff <= regWr.data;
      end
      if (wrDriveDed) begin
        driveDed_ff <= regWr.data & DED_MASK;
      end
      if (wrPinDir) begin
        pinDir_ff <= regWr.data & DED_MASK;
      end
      if (wrSharedPwm) begin
        sharedPwmEn_ff <= regWr.data;
      end
      if (wrDedPwm) begin
        dedPwmEn_ff <= regWr.data & DED_MASK;
      end
      if (wrDuty) begin
        pwmDuty_ff <= regWr.data;
      end
      if (wrWake) begin
        wakeEn_ff <= regWr.data & DED_MASK;
      end
    end
  end

  // Pin inputs pass two flip-flops before use
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync1_ff <= 3'h0;
      pinSync2_ff <= 3'h0;
    end else begin
      pinSync1_ff <= dedPinIn;
      pinSync2_ff <= pinSync1_ff;
    end
  end

  // Fixed sampling period keeps input reads cheap; faster edges are not seen
  wire logic sampleTick = (sampleCnt_ff == 32'(SAMPLE_CYCLES - 1));
  wire logic [2:0] dirDed = pinDir_ff[DED_MSB:DED_LSB];
  wire logic [2:0] wakeDed = wakeEn_ff[DED_MSB:DED_LSB];
  // In sleep only wake-enabled inputs are read; awake, every input pin
  wire logic [2:0] sampleSel = ~dirDed & (sleepMode ? wakeDed : 3'h7);
  wire logic [2:0] nxt_sample = (pinSync2_ff & sampleSel) | (pinSample_ff & ~sampleSel);
  wire logic sleepDiff = sleepMode & (|((pinSync2_ff ^ pinSample_ff) & sampleSel));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sampleCnt_ff <= 32'h0;
      pinSample_ff <= 3'h0;
      wakeChange_ff <= 1'b0;
    end else begin
      sampleCnt_ff <= sampleTick ? 32'h0 : sampleCnt_ff + 32'h1;
      wakeChange_ff <= sampleTick & sleepDiff;
      if (sampleTick) begin
        pinSample_ff <= nxt_sample;
      end
    end
  end

  // Output drive per pin
  logic [7:0] nxt_scanLine;
  logic [2:0] nxt_dedOut;
  genvar gi;
  generate
    for (gi = 0; gi < SHARED_LINES; gi++) begin : g_line
      wire logic staticLvl = sharedPwmEn_ff[gi] ? pwmLevel : driveShared_ff[gi];
      assign nxt_scanLine[gi] = measActive ? scanBurst[gi] : staticLvl;
      if (gi < DED_PINS) begin : g_ded
        wire logic pwmOn = dedPwmEn_ff[gi + DED_LSB] & dirDed[gi];
        assign nxt_dedOut[gi] = dirDed[gi] & (pwmOn ? pwmLevel : driveDed_ff[gi + DED_LSB]);
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scanLine_ff <= 8'h00;
      dedOut_ff <= 3'h0;
      dedOe_ff <= 3'h0;
    end else begin
      scanLine_ff <= nxt_scanLine;
      dedOut_ff <= nxt_dedOut;
      dedOe_ff <= dirDed;
    end
  end

  // Shared lines have no enable: always driven
  assign scanLineOut = scanLine_ff;
  assign dedPinOut = dedOut_ff;
  assign dedPinOe = dedOe_ff;
  assign dedPinState = pinSample_ff;
  assign wakeChange = wakeChange_ff;
endmodule
`default_nettype wire

//--- tb/iop_i2c_host.sv
// Two-wire bus host model that drives the slave port of the pin control block
`default_nettype none
module iop_i2c_host (
  input wire logic core_clk,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  timeunit 1ns;
  timeprecision 1ps;
  import iop_pkg::*;
  logic sclDrv = 1'b1;
  logic sdaLow = 1'b0;
  int nakCnt = 0;
  // Pull-up on the data line, so a released line reads high
  assign sdaIn = !(sdaLow || sdaOe);
  assign sclIn = sclDrv;
  task automatic hp(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Clock phases of 8 core clocks keep well above the slave's minimum
  task automatic bitIo(input logic b, output logic s);
    sdaLow <= !b;
    hp(4);
    sclDrv <= 1'b1;
    hp(4);
    s = sdaIn;
    hp(4);
    sclDrv <= 1'b0;
    hp(4);
  endtask
  task automatic start();
    sdaLow <= 1'b0;
    hp(4);
    sclDrv <= 1'b1;
    hp(8);
    sdaLow <= 1'b1;
    hp(8);
    sclDrv <= 1'b0;
    hp(4);
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    hp(4);
    sclDrv <= 1'b1;
    hp(8);
    sdaLow <= 1'b0;
    hp(8);
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(d[i], s);
    bitIo(1'b1, s);
    ack = !s;
  endtask
  task automatic getByte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, s);
      d[i] = s;
    end
    bitIo(last, s);
  endtask
  task automatic put(input logic [7:0] d);
    logic k;
    sendByte(d, k);
    nakCnt += int'(!k);
  endtask
  // Block write of one or two bytes from pointer a, low byte first
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic two);
    start();
    put({SLAVE_ADDR, 1'b0});
    put(a);
    put(d[7:0]);
    if (two) put(d[15:8]);
    stop();
  endtask
  // Read of one or two bytes through a repeated start; nack ends it
  task automatic rd(input logic [7:0] a, input int n, output logic [15:0] v);
    v = '0;
    start();
    put({SLAVE_ADDR, 1'b0});
    put(a);
    start();
    put({SLAVE_ADDR, 1'b1});
    getByte(n == 1, v[7:0]);
    if (n == 2) getByte(1'b1, v[15:8]);
    stop();
  endtask
endmodule
`default_nettype wire

//--- tb/iop_pin_ctrl_sva.sv
// Port-level assertions for the pin and PWM control block
`default_nettype none
module iop_pin_ctrl_sva #(
  parameter int SAMPLE_CYCLES = iop_pkg::SAMPLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic measActive,
  input wire logic sleepMode,
  input wire logic [7:0] scanBurst,
  input wire logic [7:0] scanLineOut,
  input wire logic [2:0] dedPinOut,
  input wire logic [2:0] dedPinOe,
  input wire logic [2:0] dedPinState,
  input wire logic wakeChange
);
  timeunit 1ns;
  timeprecision 1ps;
  import iop_pkg::*;
  logic [2:0] prevState_ff;
  int sinceChg_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prevState_ff <= 3'h0;
      sinceChg_ff <= 0;
    end else begin
      prevState_ff <= dedPinState;
      sinceChg_ff <= (dedPinState != prevState_ff) ? 0 : sinceChg_ff + 1;
    end
  end
  chk_burst_shown: assert property (measActive |=> scanLineOut == $past(scanBurst))
    else $error("shared lines do not show the burst pattern");
  chk_pwm_frozen: assert property (measActive [*3] |-> $stable(dedPinOut))
    else $error("dedicated output moved during a measurement");
  chk_input_undriven: assert property ((dedPinOut & ~dedPinOe) == 3'h0)
    else $error("level driven on a pin that is not enabled");
  chk_sda_open_drain: assert property (sdaOe |-> sdaOut == 1'b0)
    else $error("data line driven high");
  chk_wake_single: assert property (wakeChange |=> !wakeChange)
    else $error("wake pulse longer than one cycle");
  chk_wake_asleep: assert property (wakeChange |-> $past(sleepMode))
    else $error("wake pulse while awake");
  chk_sample_rate: assert property ((dedPinState != prevState_ff) |-> sinceChg_ff >= SAMPLE_CYCLES / 2)
    else $error("input state resampled too soon");
  chk_state_outputs: assert property ((dedPinState != prevState_ff)
      |-> ((dedPinState ^ prevState_ff) & dedPinOe & $past(dedPinOe)) == 3'h0)
    else $error("output pin captured as input");
  chk_reset_idle: assert property ($rose(reset_n)
      |-> dedPinOe == 3'h0 && scanLineOut == 8'h00 && !wakeChange)
    else $error("outputs not idle after reset");
endmodule
bind iop_pin_ctrl iop_pin_ctrl_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) iop_pin_ctrl_sva_inst (
  .core_clk(core_clk), .reset_n(reset_n), .sdaOut(sdaOut), .sdaOe(sdaOe), .measActive(measActive),
  .sleepMode(sleepMode), .scanBurst(scanBurst), .scanLineOut(scanLineOut), .dedPinOut(dedPinOut),
  .dedPinOe(dedPinOe), .dedPinState(dedPinState), .wakeChange(wakeChange));
`default_nettype wire

//--- tb/iop_pin_ctrl_tb.sv
// Self-checking testbench for the pin and PWM control block
`default_nettype none
`define CHK(a, e) begin actQ.push_back(16'(a)); expQ.push_back(16'(e)); end
module iop_pin_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iop_pkg::*;
  localparam int SC = 64;
  localparam int WIN = 256 * PWM_TICK_CYCLES;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic measActive = 1'b0;
  logic sleepMode = 1'b0;
  logic [7:0] scanBurst = 8'h00;
  logic [2:0] dedPinIn = 3'h0;
  logic sclIn, sdaIn, sdaOut, sdaOe, wakeChange, seen, k;
  logic [7:0] scanLineOut, r;
  logic [2:0] dedPinOut, dedPinOe, dedPinState;
  logic [15:0] v;
  logic [15:0] actQ[$];
  logic [15:0] expQ[$];
  logic [7:0] resv[3] = '{ADDR_PIN_DIRECTION, ADDR_DED_PWM_EN, ADDR_WAKE_EN};
  logic [7:0] duty[5] = '{8'h00, 8'h0a, 8'h80, 8'hfa, 8'hff};
  int seed, error_cnt, checks_done, hiS, hiD, expHi;
  iop_pin_ctrl #(.SAMPLE_CYCLES(SC)) iop_pin_ctrl_inst (.core_clk(core_clk), .reset_n(reset_n),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .measActive(measActive),
    .sleepMode(sleepMode), .scanBurst(scanBurst), .scanLineOut(scanLineOut), .dedPinIn(dedPinIn),
    .dedPinOut(dedPinOut), .dedPinOe(dedPinOe), .dedPinState(dedPinState), .wakeChange(wakeChange));
  iop_i2c_host host (.core_clk(core_clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Second process: at each clock edge takes every posted note, oldest first
  always @(posedge core_clk) begin
    while (actQ.size() > 0) begin
      checks_done++;
      if (actQ[0] !== expQ[0]) begin
        error_cnt++;
        $display("ERROR at %0t: got %h expected %h", $time, actQ[0], expQ[0]);
      end
      void'(actQ.pop_front());
      void'(expQ.pop_front());
    end
  end
  task automatic hp(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Bounded watch for a wake pulse
  task automatic waitWake(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      if (wakeChange === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic results();
    hp(2);
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    seed = 32'h9483;
    hp(6);
    reset_n <= 1'b1;
    hp(4);
    `CHK(dedPinOe, 3'h0)
    host.rd(ADDR_PIN_DIRECTION, 2, v);
    `CHK(v, 16'h0000)
    host.rd(ADDR_DED_PWM_EN, 2, v);
    `CHK(v, 16'h0000)
    host.rd(ADDR_WAKE_EN, 1, v);
    `CHK(v, 16'h0000)
    host.start();
    host.sendByte({7'h2b, 1'b0}, k);
    host.stop();
    `CHK(k, 1'b0)
    foreach (resv[i]) begin
      host.wr(resv[i], 16'h00ff, 1'b0);
      host.rd(resv[i], 1, v);
      `CHK(v, 16'h001c)
    end
    `CHK(dedPinOe, 3'h7)
    host.wr(8'h48, 16'h00ff, 1'b0);
    host.rd(8'h48, 1, v);
    `CHK(v, 16'h0000)
    // Drive bytes in one block; the duty level is still zero
    r = 8'($random(seed));
    host.wr(ADDR_DRIVE_SHARED, {8'h14, r}, 1'b1);
    hp(4);
    `CHK(scanLineOut, r)
    `CHK(dedPinOut, 3'h0)
    host.rd(ADDR_DRIVE_SHARED, 2, v);
    `CHK(v, {8'h14, r})
    host.wr(ADDR_DED_PWM_EN, 16'h0000, 1'b0);
    hp(4);
    `CHK(dedPinOut, 3'h5)
    scanBurst <= 8'($random(seed));
    measActive <= 1'b1;
    hp(3);
    `CHK(scanLineOut, scanBurst)
    measActive <= 1'b0;
    host.wr(ADDR_SHARED_PWM_EN, 16'h1cff, 1'b1);
    foreach (duty[i]) begin
      host.wr(ADDR_PWM_DUTY, {8'h00, duty[i]}, 1'b0);
      hp(4);
      hiS = 0;
      hiD = 0;
      repeat (WIN) begin
        @(posedge core_clk);
        hiS += int'(scanLineOut[0]);
        hiD += int'(dedPinOut[2]);
      end
      expHi = duty[i] <= DUTY_LOW_MAX ? 0 : duty[i] >= DUTY_HIGH_MIN ? WIN : int'(duty[i]) * PWM_TICK_CYCLES;
      `CHK(hiS, expHi)
      `CHK(hiD, expHi)
      measActive <= 1'b1;
      hp(40);
      measActive <= 1'b0;
    end
    host.wr(ADDR_PIN_DIRECTION, 16'h0018, 1'b0);
    hp(4);
    `CHK({dedPinOe, dedPinOut}, 6'h36)
    host.wr(ADDR_PIN_DIRECTION, 16'h0000, 1'b0);
    host.wr(ADDR_WAKE_EN, 16'h0004, 1'b0);
    dedPinIn <= 3'($random(seed));
    hp(SC + 8);
    `CHK(dedPinState, dedPinIn)
    sleepMode <= 1'b1;
    hp(4);
    dedPinIn <= dedPinIn ^ 3'h2;
    waitWake(2 * SC + 8);
    `CHK(seen, 1'b0)
    dedPinIn <= dedPinIn ^ 3'h1;
    waitWake(2 * SC + 8);
    `CHK(seen, 1'b1)
    if (seen !== 1'b1) begin
      results();
    end
    `CHK(host.nakCnt, 0)
    results();
  end
endmodule
`undef CHK
`default_nettype wire
